// >>> rtl/ufc_map.svh
/*
  Register offsets, field positions, reset values and counts of the
  UART flow-control block. Assumes inclusion by bare name from rtl/.
*/
`ifndef UFC_MAP_SVH
`define UFC_MAP_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define UFC_ADDR_W        4
`define UFC_OFF_IER       4'h0
`define UFC_OFF_ISR       4'h1
`define UFC_OFF_FCR       4'h2
`define UFC_OFF_MCR       4'h3
`define UFC_OFF_FEATURE_CONTROL      4'h4
`define UFC_OFF_EFR       4'h5
`define UFC_OFF_RES1      4'h6
`define UFC_OFF_RES2      4'h7
`define UFC_OFF_PAU1      4'h8
`define UFC_OFF_PAU2      4'h9
`define UFC_OFF_STAT      4'hA

// ----------------------------------------------------------------------
// field positions and masks
// ----------------------------------------------------------------------
`define UFC_EFR_ENH       4
`define UFC_EFR_SPC       5
`define UFC_EFR_AOUT      6
`define UFC_EFR_AIN       7
`define UFC_MCR_DTR       0
`define UFC_MCR_RTS       1
`define UFC_MCR_SEL       2
`define UFC_ISR_SPC       4
`define UFC_ISR_PAU       5
`define UFC_IER_ENH_MASK  8'hF0
`define UFC_FCR_ENH_MASK  8'h30
`define UFC_MCR_ENH_MASK  8'hE0
`define UFC_TBL_D         2'h3

// ----------------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------------
`define UFC_REG_RST       8'h00
`define UFC_PAUSE_CHARS   2'h2

`endif

// >>> rtl/ufc_pkg.sv
/*
  Types of the UART flow-control block: send states, module state
  records and the hysteresis decode. Assumes nothing outside.
*/
`default_nettype none

package ufc_pkg;

  typedef enum logic [1:0] {
    ufc_send_idle,
    ufc_send_first,
    ufc_send_last
  } ufc_send_t;

  typedef struct packed {
    logic seq_pause;
    logic seq_resume;
  } ufc_match_st_t;

  typedef struct packed {
    logic [7:0] interrupt_enable;
    logic [7:0] fifo_control;
    logic [7:0] modem_control;
    logic [7:0] feature_control;
    logic [7:0] enhanced_feature_control;
    logic [7:0] res1;
    logic [7:0] res2;
    logic [7:0] pau1;
    logic [7:0] pau2;
    logic [1:0] isr_flags;
    logic [7:0] rdata;
    logic       rts_n;
    logic       dtr_n;
    logic       hw_paused;
    logic       remote_stop;
    logic       tx_stop;
    logic [1:0] pause_cnt;
    logic       sw_paused;
    ufc_send_t  send;
    logic [7:0] fc_char;
    logic       fc_valid;
    logic       store;
    logic [7:0] store_data;
    logic       at_trig;
    logic       trig_irq;
  } ufc_top_st_t;

  // hysteresis in characters for table D
  function automatic logic [7:0] ufc_hyst_chars(input logic [3:0] sel);
    logic [7:0] r;
    r = 8'h00;
    unique case (sel)
      4'h0: r = 8'h00;
      4'h1: r = 8'h04;
      4'h2: r = 8'h06;
      4'h3: r = 8'h08;
      4'h4: r = 8'h08;
      4'h5: r = 8'h10;
      4'h6: r = 8'h18;
      4'h7: r = 8'h20;
      4'h8: r = 8'h28;
      4'h9: r = 8'h2C;
      4'hA: r = 8'h30;
      4'hB: r = 8'h34;
      4'hC: r = 8'h0C;
      4'hD: r = 8'h14;
      4'hE: r = 8'h1C;
      4'hF: r = 8'h24;
    endcase
    return r;
  endfunction

endpackage

`default_nettype wire

// >>> rtl/ufc_sync.sv
/*
  Pin synchroniser: three stages and an output flop per bit, a change counts once the
  second and third stages agree. Assumes asynchronous pin inputs.
*/
`default_nettype none

module ufc_sync
  import ufc_pkg::*;
#(
  parameter int W = 2
) (
  input  wire logic         mclk_i,
  input  wire logic         rst_b_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } ufc_sync_st_t;

  ufc_sync_st_t st;
  ufc_sync_st_t next_st;

  always_comb begin
    next_st    = st;
    next_st.s1 = d_i;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int i = 0; i < W; i++) begin
      if (st.s2[i] == st.s3[i]) begin
        next_st.q[i] = st.s3[i];
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q_o = st.q;

  property p_sync_agree;
    @(posedge mclk_i) disable iff (!rst_b_i)
      (st.s2 != st.s3) |=> (st.q == $past(st.q));
  endproperty
  a_sync_agree: assert property (p_sync_agree) else $error("sync output moved on disagreement");

endmodule

`default_nettype wire

// >>> rtl/ufc_rx_match.sv
/*
  Receive-side matching of pause/resume characters and of the special
  character. Assumes one received character per valid pulse.
*/
`default_nettype none

module ufc_rx_match
  import ufc_pkg::*;
(
  input  wire logic       mclk_i,
  input  wire logic       rst_b_i,
  input  wire logic [7:0] char_i,
  input  wire logic       valid_i,
  input  wire logic [1:0] rx_mode_i,
  input  wire logic [1:0] tx_mode_i,
  input  wire logic       special_en_i,
  input  wire logic [7:0] res1_i,
  input  wire logic [7:0] res2_i,
  input  wire logic [7:0] pau1_i,
  input  wire logic [7:0] pau2_i,
  output logic            pause_o,
  output logic            resume_o,
  output logic            special_o,
  output logic            keep_o
);

  ufc_match_st_t st;
  ufc_match_st_t next_st;
  logic          m_p1;
  logic          m_p2;
  logic          m_r1;
  logic          m_r2;
  logic          either;

  assign m_p1   = (char_i == pau1_i);
  assign m_p2   = (char_i == pau2_i);
  assign m_r1   = (char_i == res1_i);
  assign m_r2   = (char_i == res2_i);
  // tx on one pair while rx on both: either pair matches on its own
  assign either = tx_mode_i[1] ^ tx_mode_i[0];

  always_comb begin
    next_st  = st;
    pause_o  = 1'b0;
    resume_o = 1'b0;
    unique case (rx_mode_i)
      2'b00: begin
      end
      2'b01: begin
        pause_o  = valid_i & m_p2;
        resume_o = valid_i & m_r2;
      end
      2'b10: begin
        pause_o  = valid_i & m_p1;
        resume_o = valid_i & m_r1;
      end
      2'b11: begin
        if (either) begin
          pause_o  = valid_i & (m_p1 | m_p2);
          resume_o = valid_i & (m_r1 | m_r2);
        end else begin
          // two-character sequence: first must directly precede second
          pause_o  = valid_i & st.seq_pause & m_p2;
          resume_o = valid_i & st.seq_resume & m_r2;
        end
      end
    endcase
    if (valid_i) begin
      next_st.seq_pause  = m_p1;
      next_st.seq_resume = m_r1;
    end
    special_o = valid_i & special_en_i & m_p2;
    // consumed flow characters never reach the fifo
    keep_o    = valid_i & ~(pause_o | resume_o);
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  property p_seq_order;
    @(posedge mclk_i) disable iff (!rst_b_i)
      (rx_mode_i == 2'b11 && !either && pause_o) |-> $past(valid_i && m_p1 || !valid_i);
  endproperty
  a_seq_order: assert property (p_seq_order) else $error("sequence pause without first char");

endmodule

`default_nettype wire

// >>> rtl/ufc_top.sv
/*
  Flow-control core of one UART channel: trigger table and hysteresis
  select, enhanced-bit write gate, software pause/resume characters,
  special character detect, auto request/ready output and auto
  clear/set-ready transmit gating. Assumes the fifo, trigger tables,
  transmitter and receiver are outside and on the same clock; the
  transmitter takes a flow character only between data characters.
*/
// Decided for this implementation: the plain strobed port and the placing of the registers.
// Summary of operation
// - two feature bits pick trigger table A, B, C or D
// - tables A-C: hardware flow trips one level above, releases one below
// - table D: four-bit hysteresis code maps to a character count
// - both pairs selected: two characters sent back to back; matched back to back unless tx uses one pair
// - pause characters go two character times after reaching trigger
// - resume goes below next lower level, or trigger minus hysteresis
// - upper selection bits pick transmitted pair: none, second, first, both
// - lower bits pick received pair; 11 means either or sequence
// - enhanced bits only writable while enhanced enable is set
// - reset clears enhanced enable and every gated enhanced bit
// - special detect compares with second pause char, stores, flags status
// - special detect with second-pair matching drops char, raises both flags
// - auto output: event at trigger, high above, low below release level
// - modem bit 2 steers auto output to request or ready pin
// - auto input: transmitter stops while selected input is high
// - special, auto output and auto input enables reset to zero
// - hysteresis counts only under table D; zero means next level
// - character in progress finishes before transmit stops
`default_nettype none

`include "ufc_map.svh"

module ufc_top
  import ufc_pkg::*;
(
  input  wire logic                  mclk_i,
  input  wire logic                  rst_b_i,
  input  wire logic [`UFC_ADDR_W-1:0] reg_addr_i,
  input  wire logic [7:0]            reg_wdata_i,
  input  wire logic                  reg_wr_i,
  input  wire logic                  reg_rd_i,
  output logic      [7:0]            reg_rdata_o,
  input  wire logic [7:0]            rx_level_i,
  input  wire logic [7:0]            rx_trig_i,
  input  wire logic [7:0]            rx_trig_up_i,
  input  wire logic [7:0]            rx_trig_dn_i,
  input  wire logic                  char_tick_i,
  input  wire logic [7:0]            rx_char_i,
  input  wire logic                  rx_char_valid_i,
  output logic                       rx_store_o,
  output logic      [7:0]            rx_store_data_o,
  input  wire logic                  tx_busy_i,
  output logic                       tx_stop_o,
  input  wire logic                  fc_take_i,
  output logic                       fc_valid_o,
  output logic      [7:0]            fc_char_o,
  input  wire logic                  cts_n_i,
  input  wire logic                  dsr_n_i,
  output logic                       rts_n_o,
  output logic                       dtr_n_o,
  output logic                       trig_irq_o,
  output logic      [1:0]            trig_table_o,
  output logic      [7:0]            ier_o,
  output logic      [7:0]            fcr_o,
  output logic      [7:0]            mcr_o
);

  ufc_top_st_t st;
  ufc_top_st_t next_st;
  logic [1:0]  pin_s;
  logic        m_pause;
  logic        m_resume;
  logic        m_special;
  logic        m_keep;
  logic        enh;
  logic        tbl_d;
  logic [7:0]  hyst;
  logic [7:0]  up_lvl;
  logic [7:0]  dn_lvl;
  logic        at_trig;
  logic        tx_en;
  logic        auto_out;
  logic        req_pause;
  logic        req_resume;
  logic        in_stop;

  // ----------------------------------------------------------------------
  // submodules
  // ----------------------------------------------------------------------
  ufc_sync #(.W(2)) u_sync (
    .mclk_i  (mclk_i),
    .rst_b_i (rst_b_i),
    .d_i     ({dsr_n_i, cts_n_i}),
    .q_o     (pin_s)
  );

  ufc_rx_match u_match (
    .mclk_i       (mclk_i),
    .rst_b_i      (rst_b_i),
    .char_i       (rx_char_i),
    .valid_i      (rx_char_valid_i),
    .rx_mode_i    (st.enhanced_feature_control[1:0]),
    .tx_mode_i    (st.enhanced_feature_control[3:2]),
    .special_en_i (st.enhanced_feature_control[`UFC_EFR_SPC]),
    .res1_i       (st.res1),
    .res2_i       (st.res2),
    .pau1_i       (st.pau1),
    .pau2_i       (st.pau2),
    .pause_o      (m_pause),
    .resume_o     (m_resume),
    .special_o    (m_special),
    .keep_o       (m_keep)
  );

  // ----------------------------------------------------------------------
  // thresholds
  // ----------------------------------------------------------------------
  assign enh   = st.enhanced_feature_control[`UFC_EFR_ENH];
  assign tbl_d = (st.feature_control[7:6] == `UFC_TBL_D);
  assign hyst  = ufc_hyst_chars(st.feature_control[3:0]);
  // hysteresis only under table D and when nonzero, else next levels
  assign up_lvl = (tbl_d && hyst != 8'h00) ? rx_trig_i + hyst : rx_trig_up_i;
  assign dn_lvl = (tbl_d && hyst != 8'h00)
                ? ((hyst > rx_trig_i) ? 8'h00 : rx_trig_i - hyst) : rx_trig_dn_i;
  assign at_trig    = (rx_level_i >= rx_trig_i);
  assign tx_en      = (st.enhanced_feature_control[3:2] != 2'b00);
  assign auto_out   = st.enhanced_feature_control[`UFC_EFR_AOUT];
  assign req_pause  = tx_en && at_trig && !st.sw_paused
                    && st.pause_cnt == `UFC_PAUSE_CHARS;
  assign req_resume = tx_en && st.sw_paused && rx_level_i < dn_lvl;
  // mcr select bit: 0 uses clear-to-send, 1 uses set-ready
  assign in_stop    = st.enhanced_feature_control[`UFC_EFR_AIN]
                    && (st.modem_control[`UFC_MCR_SEL] ? pin_s[1] : pin_s[0]);

  // masked write: gated bits keep their value while enhanced enable is off
  function automatic logic [7:0] gate_wr(input logic [7:0] old, input logic [7:0] wd,
                                         input logic [7:0] mask, input logic en);
    return en ? wd : ((old & mask) | (wd & ~mask));
  endfunction

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_st = st;
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        `UFC_OFF_IER:  next_st.interrupt_enable  = gate_wr(st.interrupt_enable, reg_wdata_i, `UFC_IER_ENH_MASK, enh);
        `UFC_OFF_FCR:  next_st.fifo_control  = gate_wr(st.fifo_control, reg_wdata_i, `UFC_FCR_ENH_MASK, enh);
        `UFC_OFF_MCR:  next_st.modem_control  = gate_wr(st.modem_control, reg_wdata_i, `UFC_MCR_ENH_MASK, enh);
        `UFC_OFF_ISR: begin
          if (enh) begin
            next_st.isr_flags = st.isr_flags & ~reg_wdata_i[`UFC_ISR_PAU:`UFC_ISR_SPC];
          end
        end
        `UFC_OFF_FEATURE_CONTROL: next_st.feature_control = reg_wdata_i;
        `UFC_OFF_EFR:  next_st.enhanced_feature_control  = reg_wdata_i;
        `UFC_OFF_RES1: next_st.res1 = reg_wdata_i;
        `UFC_OFF_RES2: next_st.res2 = reg_wdata_i;
        `UFC_OFF_PAU1: next_st.pau1 = reg_wdata_i;
        `UFC_OFF_PAU2: next_st.pau2 = reg_wdata_i;
        default: begin
        end
      endcase
    end

    // read data stands only in the cycle after the strobe
    next_st.rdata = 8'h00;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        `UFC_OFF_IER:  next_st.rdata = st.interrupt_enable;
        `UFC_OFF_ISR:  next_st.rdata = {2'b00, st.isr_flags, 4'h0};
        `UFC_OFF_FCR:  next_st.rdata = st.fifo_control;
        `UFC_OFF_MCR:  next_st.rdata = st.modem_control;
        `UFC_OFF_FEATURE_CONTROL: next_st.rdata = st.feature_control;
        `UFC_OFF_EFR:  next_st.rdata = st.enhanced_feature_control;
        `UFC_OFF_RES1: next_st.rdata = st.res1;
        `UFC_OFF_RES2: next_st.rdata = st.res2;
        `UFC_OFF_PAU1: next_st.rdata = st.pau1;
        `UFC_OFF_PAU2: next_st.rdata = st.pau2;
        `UFC_OFF_STAT: next_st.rdata = {2'b00, pin_s, st.sw_paused, st.remote_stop,
                                        st.hw_paused, st.tx_stop};
        default:       next_st.rdata = 8'h00;
      endcase
    end

    // status flags: a new event wins over a clear in the same cycle
    if (m_special) begin
      next_st.isr_flags[0] = 1'b1;
    end
    if (m_pause) begin
      next_st.isr_flags[1] = 1'b1;
    end

    // receive path towards the fifo
    next_st.store      = m_keep;
    next_st.store_data = rx_char_i;

    // pause from far end holds data until its resume
    if (st.enhanced_feature_control[1:0] == 2'b00) begin
      next_st.remote_stop = 1'b0;
    end else if (m_pause) begin
      next_st.remote_stop = 1'b1;
    end else if (m_resume) begin
      next_st.remote_stop = 1'b0;
    end

    // hardware output flow control
    if (!auto_out) begin
      next_st.hw_paused = 1'b0;
    end else if (rx_level_i >= up_lvl) begin
      next_st.hw_paused = 1'b1;
    end else if (rx_level_i < dn_lvl) begin
      next_st.hw_paused = 1'b0;
    end
    // pin only low when software asserted it; auto can only release it
    next_st.rts_n = !(st.modem_control[`UFC_MCR_RTS]
                  && !(auto_out && !st.modem_control[`UFC_MCR_SEL] && st.hw_paused));
    next_st.dtr_n = !(st.modem_control[`UFC_MCR_DTR]
                  && !(auto_out && st.modem_control[`UFC_MCR_SEL] && st.hw_paused));
    next_st.at_trig  = at_trig;
    next_st.trig_irq = auto_out && at_trig && !st.at_trig;

    // data transmit stop changes only between characters
    if (!tx_busy_i) begin
      next_st.tx_stop = in_stop || st.remote_stop;
    end

    // two character times spent at or above trigger before pausing
    if (!at_trig || st.sw_paused || !tx_en) begin
      next_st.pause_cnt = 2'h0;
    end else if (char_tick_i && st.pause_cnt != `UFC_PAUSE_CHARS) begin
      next_st.pause_cnt = st.pause_cnt + 2'h1;
    end

    // flow character sender
    if (!tx_en) begin
      // selection cleared: drop any pending character and pause state
      next_st.sw_paused = 1'b0;
      next_st.fc_valid  = 1'b0;
      next_st.send      = ufc_send_idle;
    end else begin
      unique case (st.send)
        ufc_send_idle: begin
          if (req_pause || req_resume) begin
            next_st.sw_paused = req_pause;
            next_st.fc_valid  = 1'b1;
            // second-only uses the second char; first or both starts on first
            if (st.enhanced_feature_control[3]) begin
              next_st.fc_char = req_pause ? st.pau1 : st.res1;
            end else begin
              next_st.fc_char = req_pause ? st.pau2 : st.res2;
            end
            next_st.send = (st.enhanced_feature_control[3:2] == 2'b11) ? ufc_send_first : ufc_send_last;
          end
        end
        ufc_send_first: begin
          if (fc_take_i) begin
            next_st.fc_char = st.sw_paused ? st.pau2 : st.res2;
            next_st.send    = ufc_send_last;
          end
        end
        ufc_send_last: begin
          if (fc_take_i) begin
            next_st.fc_valid = 1'b0;
            next_st.send     = ufc_send_idle;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      st       <= '0;
      st.rts_n <= 1'b1;
      st.dtr_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata_o     = st.rdata;
  assign rx_store_o      = st.store;
  assign rx_store_data_o = st.store_data;
  assign tx_stop_o       = st.tx_stop;
  assign fc_valid_o      = st.fc_valid;
  assign fc_char_o       = st.fc_char;
  assign rts_n_o         = st.rts_n;
  assign dtr_n_o         = st.dtr_n;
  assign trig_irq_o      = st.trig_irq;
  assign trig_table_o    = st.feature_control[7:6];
  assign ier_o           = st.interrupt_enable;
  assign fcr_o           = st.fifo_control;
  assign mcr_o           = st.modem_control;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);

  property p_enh_gate;
    reg_wr_i && reg_addr_i == `UFC_OFF_MCR && !enh |=> mcr_o[7:5] == $past(mcr_o[7:5]);
  endproperty
  a_enh_gate: assert property (p_enh_gate) else $error("gated modem bits changed");

  property p_rst_zero;
    disable iff (1'b0) !rst_b_i |=> st.enhanced_feature_control == `UFC_REG_RST && ier_o == `UFC_REG_RST;
  endproperty
  a_rst_zero: assert property (p_rst_zero) else $error("enhanced bits not cleared");

  property p_stop_hold;
    tx_busy_i |=> tx_stop_o == $past(tx_stop_o);
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("stop moved mid character");

  property p_pause_wait;
    $rose(st.sw_paused) |-> $past(st.pause_cnt) == `UFC_PAUSE_CHARS;
  endproperty
  a_pause_wait: assert property (p_pause_wait) else $error("pause sent too early");

  property p_fc_hold;
    fc_valid_o && !fc_take_i |=> fc_valid_o && $stable(fc_char_o);
  endproperty
  a_fc_hold: assert property (p_fc_hold) else $error("flow char dropped");

  property p_no_store;
    rx_char_valid_i && (m_pause || m_resume) |=> !rx_store_o;
  endproperty
  a_no_store: assert property (p_no_store) else $error("flow char stored");

  property p_rts_release;
    auto_out && st.hw_paused && !st.modem_control[`UFC_MCR_SEL] |=> rts_n_o;
  endproperty
  a_rts_release: assert property (p_rts_release) else $error("request pin not released");

  property p_trip;
    auto_out && rx_level_i >= up_lvl |=> st.hw_paused;
  endproperty
  a_trip: assert property (p_trip) else $error("auto output did not trip");

  property p_special;
    rx_char_valid_i && st.enhanced_feature_control[`UFC_EFR_SPC] && rx_char_i == st.pau2 |=> st.isr_flags[0];
  endproperty
  a_special: assert property (p_special) else $error("special flag not set");

endmodule

`default_nettype wire

// >>> tb/ufc_remote_model.sv
/*
  Far side of the modem lines: drives clear/set-ready and takes flow
  characters one at a time. Assumes the bench clock and stop request.
*/
`default_nettype none

module ufc_remote_model (
  input  wire logic mclk_i,
  input  wire logic stop_i,
  input  wire logic fc_valid_i,
  output logic      cts_n_o,
  output logic      dsr_n_o,
  output logic      fc_take_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cts_n_o = 1'b0;
    dsr_n_o = 1'b0;
    fc_take_o = 1'b0;
  end
  always @(posedge mclk_i) begin
    cts_n_o <= stop_i;
    dsr_n_o <= stop_i;
    // every other cycle: the design needs one edge to load the next char
    fc_take_o <= fc_valid_i && !fc_take_o;
  end
endmodule

`default_nettype wire

// >>> tb/tb_top.sv
/*
  Register-level bench of the flow-control core. Assumes the design
  files and the remote model are compiled before it.
*/
`default_nettype none
`include "ufc_map.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic       mclk_i, rst_b_i, reg_wr_i, reg_rd_i, char_tick_i, rx_char_valid_i, stop;
  logic [3:0] reg_addr_i;
  logic [7:0] reg_wdata_i, rx_level_i, rx_trig_i, rx_trig_up_i, rx_trig_dn_i, rx_char_i, v;
  logic [7:0] reg_rdata_o, rx_store_data_o, fc_char_o;
  logic [1:0] trig_table_o;
  logic       rx_store_o, tx_stop_o, fc_valid_o, rts_n_o, dtr_n_o, cts_n_i, dsr_n_i, fc_take_i;
  logic       tx_busy, trig_irq;
  logic [7:0] interrupt_enable, fifo_control, modem_control;
  int         miscompares, checks_done, cyc, irqs;
  logic [7:0] q[$];

  ufc_top DUT (.mclk_i, .rst_b_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .rx_level_i, .rx_trig_i, .rx_trig_up_i, .rx_trig_dn_i, .char_tick_i,
    .rx_char_i, .rx_char_valid_i, .rx_store_o, .rx_store_data_o, .tx_busy_i(tx_busy),
    .tx_stop_o, .fc_take_i, .fc_valid_o, .fc_char_o, .cts_n_i, .dsr_n_i, .rts_n_o,
    .dtr_n_o, .trig_irq_o(trig_irq), .trig_table_o, .ier_o(interrupt_enable), .fcr_o(fifo_control), .mcr_o(modem_control));
  ufc_remote_model far (.mclk_i, .stop_i(stop), .fc_valid_i(fc_valid_o),
    .cts_n_o(cts_n_i), .dsr_n_o(dsr_n_i), .fc_take_o(fc_take_i));

  // ----------------------------------------------------------------
  // clock, timeout, verdict
  // ----------------------------------------------------------------
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  task automatic print_verdict();
    if (miscompares == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      print_verdict();
    end
    if (fc_take_i && fc_valid_o) q.push_back(fc_char_o);
    if (trig_irq) irqs++;
  end

  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checks_done++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1 v = reg_rdata_o;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic rx(input logic [7:0] c);
    @(posedge mclk_i);
    rx_char_i <= c;
    rx_char_valid_i <= 1'b1;
    @(posedge mclk_i);
    rx_char_valid_i <= 1'b0;
    #1 chk("store", {7'h00, rx_store_o}, {7'h00, c != 8'h93 || !v[0]});
    chk("store data", rx_store_data_o, c);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    {rst_b_i, reg_wr_i, reg_rd_i, char_tick_i, rx_char_valid_i, stop, tx_busy} = '0;
    {reg_addr_i, reg_wdata_i, rx_level_i, rx_trig_i, rx_char_i} = '0;
    rx_trig_up_i = 8'h3C;
    rx_trig_dn_i = 8'h10;
    step(10);
    @(posedge mclk_i) rst_b_i <= 1'b1;
    chk("rts_n", {rts_n_o, dtr_n_o}, 8'h03);
    rd(`UFC_OFF_EFR); chk("efr", v, 8'h00);
    wr(`UFC_OFF_IER, 8'hFF); rd(`UFC_OFF_IER); chk("ier", v, 8'h0F);
    wr(`UFC_OFF_EFR, 8'h10); wr(`UFC_OFF_IER, 8'hFF); wr(`UFC_OFF_EFR, 8'h00);
    wr(`UFC_OFF_IER, 8'h00); rd(`UFC_OFF_IER); chk("ier", v, 8'hF0);
    wr(`UFC_OFF_MCR, 8'hE0); wr(`UFC_OFF_FCR, 8'h3F); step(1);
    chk("mcr", modem_control, 8'h00); chk("fcr", fifo_control, 8'h0F); chk("ier_o", interrupt_enable, 8'hF0);
    wr(`UFC_OFF_EFR, 8'h10); wr(`UFC_OFF_FEATURE_CONTROL, 8'hC5); step(1);
    chk("table", {6'h00, trig_table_o}, 8'h03);
    wr(`UFC_OFF_PAU1, 8'h13); wr(`UFC_OFF_PAU2, 8'h93);
    wr(`UFC_OFF_RES1, 8'h11); wr(`UFC_OFF_RES2, 8'h91); wr(`UFC_OFF_EFR, 8'h1C);
    rx_trig_i <= 8'h38;
    rx_level_i <= 8'h38;
    for (int i = 0; i < 2; i++) begin
      step(6);
      chk("pause early", q.size(), 8'h00);
      @(posedge mclk_i) char_tick_i <= 1'b1;
      @(posedge mclk_i) char_tick_i <= 1'b0;
    end
    step(10);
    chk("pause1", q[0], 8'h13); chk("pause2", q[1], 8'h93);
    @(posedge mclk_i) rx_level_i <= 8'h28;
    step(10); chk("no resume", q.size(), 8'h02);
    @(posedge mclk_i) rx_level_i <= 8'h27;
    step(10);
    chk("resume1", q[2], 8'h11); chk("resume2", q[3], 8'h91);
    wr(`UFC_OFF_EFR, 8'h90); stop <= 1'b1; tx_busy <= 1'b1; step(10);
    chk("tx hold", {7'h00, tx_stop_o}, 8'h00);
    @(posedge mclk_i) tx_busy <= 1'b0;
    step(2); chk("tx stop", {7'h00, tx_stop_o}, 8'h01);
    @(posedge mclk_i) stop <= 1'b0;
    step(10); chk("tx go", {7'h00, tx_stop_o}, 8'h00);
    v = 8'h00;
    wr(`UFC_OFF_EFR, 8'h30); rx(8'h93); rx(8'h55);
    rd(`UFC_OFF_ISR); chk("isr spc", v & 8'h30, 8'h10);
    wr(`UFC_OFF_ISR, 8'h30); wr(`UFC_OFF_EFR, 8'h31); v = 8'h01; rx(8'h93);
    rd(`UFC_OFF_ISR); chk("isr both", v & 8'h30, 8'h30);
    wr(`UFC_OFF_EFR, 8'h10); wr(`UFC_OFF_EFR, 8'h13);
    v = 8'h01; rx(8'h13); rx(8'h93);
    wr(`UFC_OFF_FEATURE_CONTROL, 8'h00); wr(`UFC_OFF_MCR, 8'h03); wr(`UFC_OFF_EFR, 8'h50);
    rx_level_i <= 8'h3B; step(6); chk("pins", {rts_n_o, dtr_n_o}, 8'h00);
    @(posedge mclk_i) rx_level_i <= 8'h3C;
    step(6); chk("pins", {rts_n_o, dtr_n_o}, 8'h02);
    @(posedge mclk_i) rx_level_i <= 8'h0F;
    step(6); chk("pins", {rts_n_o, dtr_n_o}, 8'h00);
    step(2); chk("irq", irqs[7:0], 8'h01);
    print_verdict();
  end
endmodule

`default_nettype wire
